// [crtc_glue.sv]
// Shared bus glue between a multiplexed-bus CPU and a display controller
`timescale 1ns/1ps
`default_nettype none

module crtc_glue (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire crtc_glue_pkg::pins_s          pins,
  output var  logic [7:0]                    upper_addr,
  output var  logic                          upper_addr_oe,
  output var  logic                          latch_en_n,
  output var  crtc_glue_pkg::slave_strobes_s slave_strobes,
  output var  logic                          slave_strobes_oe,
  output var  logic                          mem_io,
  output var  logic                          mem_io_oe
);

  //----------------------------------------------------------------------------
  // Behaviour summary
  //----------------------------------------------------------------------------
  // The block sits between one multiplexed-bus CPU and one display controller.
  // A single ownership pin chooses which set of pin drivers is live:
  //   - CPU master: the CPU read, write, latch-enable and direction pins are
  //     converted into the controller's slave strobes, whose drivers are on.
  //   - Controller master: the upper-address latch drives its outputs, the
  //     memory qualifier is driven high and the slave strobe drivers are off.
  // Every pin passes two flops first, so all paths see two cycles of extra
  // latency; the output flops add one more. Ownership changes reach the
  // drive enables four edges after the pin moves.
  // The drive enables are active high here; a low-active buffer enable on
  // the board is simply their inverse.
  // Wait states and recovery spacing are the CPU's job; this block only
  // forwards strobes and does not stretch or space them.
  // The latch takes its byte on the trailing edge of the address strobe as
  // seen after synchronisation; the byte passes the same two flops, so it
  // must still stand on the bus at the first clock edge that samples the strobe high.
  // Limitation: a strobe shorter than one clock cycle may be missed.

  //----------------------------------------------------------------------------
  // Input synchronisers
  //----------------------------------------------------------------------------
  crtc_glue_pkg::pins_s sync1_r;  // First stage, read only by stage two
  crtc_glue_pkg::pins_s sync2_r;  // Stable copy for all logic
  logic                 as_prev_r; // Previous stable address strobe

  // Two flops per pin; costs two cycles of latency on every path
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // Idle levels: a reset of all ones would fake ownership for two cycles
      sync1_r   <= crtc_glue_pkg::PINS_IDLE;
      sync2_r   <= crtc_glue_pkg::PINS_IDLE;
      as_prev_r <= crtc_glue_pkg::STROBE_IDLE;
    end else begin
      sync1_r   <= pins;
      sync2_r   <= sync1_r;
      as_prev_r <= sync2_r.addr_strobe_n;
    end
  end

  //----------------------------------------------------------------------------
  // Ownership and output paths
  //----------------------------------------------------------------------------
  crtc_glue_pkg::owner_e         owner_r;      // Current bus owner
  crtc_glue_pkg::owner_e         owner_nxt;
  logic [7:0]                    upper_r;      // Upper-address latch
  logic [7:0]                    upper_nxt;
  logic                          upper_oe_r;   // Latch output enable
  logic                          upper_oe_nxt;
  logic                          en_n_r;       // Latch clock enable, low active
  logic                          en_n_nxt;
  crtc_glue_pkg::slave_strobes_s strb_r;       // Converted slave strobes
  crtc_glue_pkg::slave_strobes_s strb_nxt;
  logic                          strb_oe_r;    // Strobe driver enable
  logic                          strb_oe_nxt;
  logic                          mio_oe_r;     // Memory qualifier drive enable
  logic                          mio_oe_nxt;
  logic                          mio_r;        // Memory qualifier level
  logic                          mio_nxt;
  logic                          as_rise;      // Trailing edge of address strobe
  logic [7:0]                    captured;     // Byte masked per addressing mode

  // Next-value logic for every output path
  always_comb begin
    // Single ownership indication picks the path  (see R15)
    owner_nxt = sync2_r.hold_ack ? crtc_glue_pkg::OWN_CRTC : crtc_glue_pkg::OWN_CPU;
    as_rise   = as_prev_r == 1'b0 && sync2_r.addr_strobe_n == 1'b1;
    captured  = sync2_r.muxed_bus_low_byte;
    // Segmented mode keeps only seven bits  (see R1) (see R2)
    if (!sync2_r.linear_mode) begin
      captured[crtc_glue_pkg::SEG_TOP_BIT] = 1'b0;
    end
    upper_nxt = upper_r;
    // Load on strobe trailing edge when enabled  (see R5)
    if (as_rise && !en_n_r) begin
      upper_nxt = captured;
    end
    // Enable only in the upper-address cycle  (see R4)
    en_n_nxt = !(owner_r == crtc_glue_pkg::OWN_CRTC && !sync2_r.crtc_rw);
    // Latch drives only while the controller masters  (see R3)
    upper_oe_nxt = owner_r == crtc_glue_pkg::OWN_CRTC;
    // Memory qualifier forced high under controller mastership  (see R10)
    mio_oe_nxt = owner_r == crtc_glue_pkg::OWN_CRTC;
    // Controller only ever addresses memory  (see R10)
    mio_nxt    = crtc_glue_pkg::MEM_SPACE;
    // Strobe conversion for the CPU-master path
    strb_nxt.data_strobe_n = sync2_r.cpu_rd_n & sync2_r.cpu_wr_n;  // see R6
    strb_nxt.addr_strobe_n = !sync2_r.cpu_ale;                      // see R7
    strb_nxt.rw            = !sync2_r.cpu_xfer_direction;           // see R8
    // Strobe drivers on only while the CPU masters  (see R9)
    strb_oe_nxt = owner_r == crtc_glue_pkg::OWN_CPU;
  end

  // Register stage; all outputs come from here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      owner_r    <= crtc_glue_pkg::OWN_CPU;
      upper_r    <= crtc_glue_pkg::UPPER_RST;
      upper_oe_r <= 1'b0;
      en_n_r     <= 1'b1;
      strb_r     <= '{crtc_glue_pkg::STROBE_IDLE, crtc_glue_pkg::STROBE_IDLE, 1'b1};
      strb_oe_r  <= 1'b0;
      mio_oe_r   <= 1'b0;
      mio_r      <= crtc_glue_pkg::MEM_SPACE;
    end else begin
      owner_r    <= owner_nxt;
      upper_r    <= upper_nxt;
      upper_oe_r <= upper_oe_nxt;
      en_n_r     <= en_n_nxt;
      strb_r     <= strb_nxt;
      strb_oe_r  <= strb_oe_nxt;
      mio_oe_r   <= mio_oe_nxt;
      mio_r      <= mio_nxt;
    end
  end

  // Bus clock is the system clock; no second domain here  (see R11) (see R12)
  assign upper_addr       = upper_r;
  assign upper_addr_oe    = upper_oe_r;
  assign latch_en_n       = en_n_r;
  assign slave_strobes    = strb_r;
  assign slave_strobes_oe = strb_oe_r;
  assign mem_io           = mio_r;
  assign mem_io_oe        = mio_oe_r;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence as_trailing_s;
    !sync2_r.addr_strobe_n ##1 sync2_r.addr_strobe_n;
  endsequence

  sequence enabled_trailing_s;
    (!en_n_r && !as_prev_r) ##0 sync2_r.addr_strobe_n;
  endsequence

  owner_follow_a: assert property (sync2_r.hold_ack |=> owner_r == crtc_glue_pkg::OWN_CRTC) // see R15
    else $error("owner did not follow hold acknowledge");
  latch_oe_a: assert property (upper_addr_oe == ($past(owner_r) == crtc_glue_pkg::OWN_CRTC)) // see R3
    else $error("latch output enable wrong for owner");
  clk_en_a: assert property (!latch_en_n |-> $past(owner_r) == crtc_glue_pkg::OWN_CRTC && !$past(sync2_r.crtc_rw)) // see R4
    else $error("latch enable outside upper address cycle");
  load_a: assert property (enabled_trailing_s |=> upper_addr == $past(captured)) // see R5
    else $error("latch did not load on trailing strobe edge");
  hold_a: assert property (as_trailing_s ##0 en_n_r |=> $stable(upper_addr)) // see R4
    else $error("latch loaded while disabled");
  seg_mask_a: assert property (enabled_trailing_s ##0 !sync2_r.linear_mode |=> !upper_addr[7]) // see R1
    else $error("segmented capture kept top bit");
  ds_a: assert property ((!sync2_r.cpu_rd_n || !sync2_r.cpu_wr_n) |=> !slave_strobes.data_strobe_n) // see R6
    else $error("data strobe missed CPU strobe");
  as_rw_a: assert property (1'b1 |=> slave_strobes.addr_strobe_n == !$past(sync2_r.cpu_ale)
                            && slave_strobes.rw == !$past(sync2_r.cpu_xfer_direction)) // see R7
    else $error("address strobe or read/write not inverted");
  strb_oe_a: assert property (slave_strobes_oe |-> !upper_addr_oe && !mem_io_oe) // see R9
    else $error("strobe drivers on with controller master");
  mio_a: assert property (sync2_r.hold_ack ##1 sync2_r.hold_ack |=> mem_io_oe && mem_io) // see R10
    else $error("memory qualifier not driven high");

  // Ownership falls back to the CPU as soon as the grant drops
  owner_back_a: assert property (!sync2_r.hold_ack |=> owner_r == crtc_glue_pkg::OWN_CPU) // see R15
    else $error("owner did not return to CPU");
  // Latch outputs and strobe drivers never drive together
  oe_excl_a: assert property (upper_addr_oe |-> !slave_strobes_oe && mem_io_oe) // see R3
    else $error("latch and strobe drivers overlap");
  // Qualifier level is always memory
  mio_level_a: assert property (mem_io) // see R10
    else $error("memory qualifier level low");
  // Strobe drivers come on under CPU ownership
  strb_on_a: assert property (owner_r == crtc_glue_pkg::OWN_CPU |=> slave_strobes_oe) // see R9
    else $error("strobe drivers off with CPU master");
  // Qualifier driver off under CPU ownership
  mio_off_a: assert property (owner_r == crtc_glue_pkg::OWN_CPU |=> !mem_io_oe) // see R10
    else $error("memory qualifier driven with CPU master");
  // Latch enable never given while the CPU owns the bus
  en_cpu_a: assert property (owner_r == crtc_glue_pkg::OWN_CPU |=> latch_en_n) // see R4
    else $error("latch enabled with CPU master");
  // Latch enable given in every upper-address cycle
  en_crtc_a: assert property (owner_r == crtc_glue_pkg::OWN_CRTC && !sync2_r.crtc_rw
                              |=> !latch_en_n) // see R4
    else $error("latch enable missing in upper address cycle");
  // Data strobe idle while neither CPU strobe is active
  ds_idle_a: assert property (sync2_r.cpu_rd_n && sync2_r.cpu_wr_n
                              |=> slave_strobes.data_strobe_n) // see R6
    else $error("data strobe active without CPU strobe");
  // Linear mode keeps the top bit of the byte
  lin_keep_a: assert property (enabled_trailing_s ##0 sync2_r.linear_mode
                               |=> upper_addr[7] == $past(sync2_r.muxed_bus_low_byte[7])) // see R2
    else $error("linear capture lost top bit");
  // No load away from a trailing strobe edge
  no_load_a: assert property (!as_rise |=> $stable(upper_addr)) // see R5
    else $error("latch changed without trailing edge");

endmodule

`default_nettype wire

// [crtc_glue_pkg.sv]
// Shared constants and types for the CPU / display controller shared bus glue
//------------------------------------------------------------------------------
// Overview of operation
// R1 - Capture upper address: 7 or 8 bits
// R2 - Programmed mode selects segmented or linear addressing
// R3 - Latch outputs driven only while controller masters
// R4 - Latch enable: controller master and write-low
// R5 - Latch loads on rising address strobe edge
// R6 - Data strobe asserted on CPU read or write
// R7 - Address strobe is inverted CPU latch enable
// R8 - Read/write is inverted CPU direction output
// R9 - Converted strobes driven only while CPU masters
// R10 - Memory qualifier driven high under controller mastership
// R11 - Both masters share one bus clock
// R12 - Bus clock kept synchronous with character clock
// R13 - CPU inserts one wait state per access
// R14 - CPU leaves 330 ns between slave accesses
// R15 - One ownership signal selects signal paths
//------------------------------------------------------------------------------
package crtc_glue_pkg;

  localparam int          UPPER_W        = 8;        // Latch width in linear mode
  localparam int          SEG_TOP_BIT    = 7;        // Bit unused in segmented mode
  localparam logic [7:0]  UPPER_RST      = 8'h00;    // Latch value after reset
  localparam logic        STROBE_IDLE    = 1'b1;     // Idle level of low-active strobes
  localparam logic        MEM_SPACE      = 1'b1;     // Memory/IO qualifier for memory
  localparam int          RECOVERY_NS    = 330;      // Slave recovery time, far side
  localparam int          CLK_PERIOD_NS  = 100;      // Bus clock period
  localparam int          RECOVERY_CYC   = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus ownership, Gray coded
  typedef enum logic [1:0] {
    OWN_CPU  = 2'b00,
    OWN_CRTC = 2'b01
  } owner_e;

  // Pin levels sampled from the shared bus
  typedef struct packed {
    logic       hold_ack;            // High while the display controller owns the bus
    logic       cpu_rd_n;            // CPU read strobe
    logic       cpu_wr_n;            // CPU write strobe
    logic       cpu_ale;             // CPU address latch enable
    logic       cpu_xfer_direction;  // CPU transmit/receive-bar
    logic       addr_strobe_n;       // Controller address strobe as master
    logic       crtc_rw;             // Controller read/write-bar as master
    logic       linear_mode;         // Controller programmed for linear addressing
    logic [7:0] muxed_bus_low_byte;  // Low byte of the multiplexed bus
  } pins_s;

  // Strobes presented to the controller as slave
  typedef struct packed {
    logic data_strobe_n;
    logic addr_strobe_n;
    logic rw;
  } slave_strobes_s;

  // Idle pin levels loaded into the synchronisers at reset, so no false
  // ownership, strobe or trailing edge shows up in the first cycles after it
  localparam pins_s PINS_IDLE = '{
    hold_ack:           1'b0,
    cpu_rd_n:           STROBE_IDLE,
    cpu_wr_n:           STROBE_IDLE,
    cpu_ale:            1'b0,
    cpu_xfer_direction: 1'b0,
    addr_strobe_n:      STROBE_IDLE,
    crtc_rw:            1'b1,
    linear_mode:        1'b0,
    muxed_bus_low_byte: 8'h00
  };

endpackage

// [crtc_master_model.sv]
// Behavioural display controller acting as bus master for upper-address cycles
`timescale 1ns/1ps
`default_nettype none
module crtc_master_model (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic       rw_in,
  input  wire logic [7:0] byte_in,
  output var  logic       as_n,
  output var  logic       rw,
  output var  logic [7:0] ad
);
  int cnt = 0;  // Cycle count of one bus cycle
  initial begin
    as_n = 1'b1;
    rw   = 1'b1;
    ad   = 8'h5A;
  end
  // Runs on the shared bus clock, same as the CPU
  always @(posedge clk) begin
    if (start && cnt == 0) begin
      cnt  <= 10;  // Long cycle keeps accesses well apart
      rw   <= rw_in;
      ad   <= byte_in;  // Upper address on the low byte
      as_n <= 1'b0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 7) as_n <= 1'b1;  // Trailing edge of the strobe
      if (cnt == 1) begin
        ad <= ~ad;  // Released: never show the stale byte
        rw <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb_cpu_crtc_shared_bus_glue.sv]
// Self-checking bench for the shared bus glue
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_crtc_shared_bus_glue;
  logic clk = 0, rstn = 0, hold = 0, rd_n = 1, wr_n = 1, ale = 0, dir = 0, lin = 0;
  logic start = 0, rw_in = 1, as_n, crw, upper_addr_oe, latch_en_n, slave_strobes_oe;
  logic mem_io, mem_io_oe;
  logic [7:0] byte_in = 8'h00, exp_up = 8'h00, ad, upper_addr;
  logic [31:0] rnd = 32'hA86E;  // Fixed seed keeps runs repeatable
  crtc_glue_pkg::pins_s pins;
  crtc_glue_pkg::slave_strobes_s slave_strobes;
  int failures = 0, n_checks = 0;
  assign pins = {hold, rd_n, wr_n, ale, dir, as_n, crw, lin, ad};
  always #50 clk = ~clk;
  crtc_glue uut (.clk(clk), .rstn(rstn), .pins(pins), .upper_addr(upper_addr),
    .upper_addr_oe(upper_addr_oe), .latch_en_n(latch_en_n), .slave_strobes(slave_strobes),
    .slave_strobes_oe(slave_strobes_oe), .mem_io(mem_io), .mem_io_oe(mem_io_oe));
  crtc_master_model peer (.clk(clk), .start(start), .rw_in(rw_in), .byte_in(byte_in),
    .as_n(as_n), .rw(crw), .ad(ad));
  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Drive enables follow the single ownership input
  task automatic own_chk;
    chk("oe", {upper_addr_oe, slave_strobes_oe, mem_io_oe, mem_io}, {hold, ~hold, hold, 1'b1});
  endtask
  // One upper-address cycle from the controller model
  task automatic lat(input logic rw, input logic [7:0] b);
    @(negedge clk);
    start = 1;
    rw_in = rw;
    byte_in = b;
    cyc(1);
    start = 0;
    cyc(3);
    chk("en", {7'h00, latch_en_n}, {7'h00, ~(hold & ~rw)});
    chk("early", upper_addr, exp_up);
    cyc(9);
    if (hold && !rw) exp_up = lin ? b : {1'b0, b[6:0]};
    chk("upper", upper_addr, exp_up);
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  //----------------------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------------------
  initial begin
    cyc(12);
    chk("rst", {upper_addr_oe, slave_strobes_oe, mem_io_oe, latch_en_n, slave_strobes}, 8'h0F);
    chk("rst_up", upper_addr, 8'h00);
    rstn = 1;
    cyc(6);
    // All strobe combinations first, then random ones
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      {rd_n, wr_n, ale, dir} = (i < 16) ? i[3:0] : rnd[3:0];
      cyc(5);  // Wait state and recovery kept by spacing
      chk("strb", {5'h00, slave_strobes}, {5'h00, rd_n & wr_n, ~ale, ~dir});
      own_chk();
    end
    lat(1'b0, 8'hC3);  // Ignored while the CPU owns the bus
    hold = 1;
    cyc(6);
    own_chk();
    for (int j = 0; j < 8; j++) begin
      rnd = lfsr(rnd);
      lin = j[0];
      lat(j == 3, (j < 2) ? 8'hFF : rnd[7:0]);
    end
    hold = 0;
    cyc(6);
    own_chk();
    rstn = 0;  // Second reset in mid-run
    cyc(2);
    chk("rst2", upper_addr, 8'h00);
    rstn = 1;
    cyc(6);
    own_chk();
    end_of_test();
  end
endmodule
`default_nettype wire
